// >>> core/serial_port_select_enable.sv
/*
 * Four-channel serial port control: input select, loop-back, driver
 * output-enable latch and signal detect level select, with an AHB-Lite
 * register slave. Assumes control pins are asynchronous to hclk and the
 * transmit serial data comes from logic on hclk.
 */
`timescale 1ns/1ns
`default_nettype none

module serial_port_select_enable
  import serial_port_pkg::*;
#(
  parameter logic [23:0] DRV_MAP = DRV_MAP_DEFAULT
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic      [31:0]  hrdata,
  input  wire logic         device_reset_n,
  input  wire logic         global_loopback_en,
  input  wire logic         drv_enable_latch_open,
  input  wire logic [7:0]   shared_enable_bus,
  input  wire logic [3:0]   rx_input_choose,
  input  wire logic [1:0]   sig_detect_level_sel,
  input  wire logic [3:0]   primary_serial_in,
  input  wire logic [3:0]   secondary_serial_in,
  input  wire logic [3:0]   tx_serial_data,
  output logic      [3:0]   cdr_serial_in,
  output logic      [7:0]   serial_driver_pair,
  output logic      [7:0]   serial_driver_en,
  output logic      [7:0]   sig_detect_threshold
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [SYNC_W-1:0] sync_out;
  logic              drst_s;
  logic              open_s;
  logic              lbpin_s;
  logic [1:0]        lvl_s;
  logic [3:0]        sel_s;
  logic [3:0]        pri_s;
  logic [3:0]        sec_s;
  logic [7:0]        bus_s;
  logic [31:0]       ctrl_reg;
  logic              lb_eff;
  logic [7:0]        held_reg;
  logic [7:0]        bus_eff;
  logic [7:0]        en_map;
  logic [7:0]        th_next;
  logic              wr_pend_reg;
  logic [7:0]        addr_reg;

  pin_sync3 #(.W(SYNC_W)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  ({~device_reset_n, drv_enable_latch_open, global_loopback_en,
               sig_detect_level_sel, rx_input_choose, primary_serial_in,
               secondary_serial_in, shared_enable_bus}),
    .pin_out (sync_out)
  );

  // Split synchronised pins; device reset held active-high internally
  assign drst_s  = sync_out[24];
  assign open_s  = sync_out[23];
  assign lbpin_s = sync_out[22];
  assign lvl_s   = sync_out[21:20];
  assign sel_s   = sync_out[19:16];
  assign pri_s   = sync_out[15:12];
  assign sec_s   = sync_out[11:8];
  assign bus_s   = sync_out[7:0];
  assign lb_eff  = lbpin_s | ctrl_reg[CTRL_LOOP_BIT];

  // ****************************************************************
  // Output-enable latch
  // ****************************************************************
  // Capture bus while open, clear on sampled device reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_reg <= '0;
    end else if (drst_s) begin
      held_reg <= '0;
    end else if (open_s) begin
      held_reg <= bus_s;
    end
  end

  // Transparent when open, held value when closed
  always_comb begin
    if (drst_s) begin
      bus_eff = '0;
    end else if (open_s) begin
      bus_eff = bus_s;
    end else begin
      bus_eff = held_reg;
    end
  end

  // Fixed bus-bit to driver map
  always_comb begin
    en_map = '0;
    for (int d = 0; d < DRIVERS; d++) begin
      en_map[d] = bus_eff[DRV_MAP[d*3 +: 3]];
    end
  end

  // ****************************************************************
  // Serial paths
  // ****************************************************************
  // Receiver source: loop-back, else primary or secondary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cdr_serial_in <= '0;
    end else if (lb_eff) begin
      cdr_serial_in <= tx_serial_data;
    end else begin
      cdr_serial_in <= (sel_s & pri_s) | (~sel_s & sec_s);
    end
  end

  // Drivers: enable from latch, data or constant one in loop-back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_driver_en   <= '0;
      serial_driver_pair <= '0;
    end else begin
      serial_driver_en <= en_map;
      for (int d = 0; d < DRIVERS; d++) begin
        if (!en_map[d]) begin
          serial_driver_pair[d] <= 1'b0;
        end else if (lb_eff) begin
          serial_driver_pair[d] <= 1'b1;
        end else begin
          serial_driver_pair[d] <= tx_serial_data[d/2];
        end
      end
    end
  end

  // ****************************************************************
  // Signal detect level
  // ****************************************************************
  // Three-level code to threshold; code 3 reads as high
  always_comb begin
    unique case (lvl_s)
      LVL_LOW: th_next = TH_LOW;
      LVL_MID: th_next = TH_MID;
      default: th_next = TH_HIGH;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sig_detect_threshold <= TH_LOW;
    end else begin
      sig_detect_threshold <= th_next;
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= '0;
      hrdata      <= '0;
    end else begin
      wr_pend_reg <= hsel & hready & htrans[1] & hwrite;
      addr_reg    <= haddr[7:0];
      hrdata      <= '0;
      if (hsel && hready && htrans[1] && !hwrite) begin
        if (haddr[7:0] == CTRL_OFF) begin
          hrdata <= ctrl_reg;
        end else if (haddr[7:0] == STATUS_OFF) begin
          hrdata <= {14'h0, lvl_s, 1'b0, drst_s, open_s, lb_eff,
                     sel_s, serial_driver_en};
        end
      end
    end
  end

  // Control register write in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_pend_reg && addr_reg == CTRL_OFF) begin
      ctrl_reg <= {31'h0, hwdata[CTRL_LOOP_BIT]};
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_primary_pick: assert property (@(posedge hclk) disable iff (!hresetn)
    !lb_eff |=> cdr_serial_in == $past((sel_s & pri_s) | (~sel_s & sec_s)))
    else $error("Receiver source does not follow input selector");

  a_loop_route: assert property (@(posedge hclk) disable iff (!hresetn)
    lb_eff |=> cdr_serial_in == $past(tx_serial_data))
    else $error("Loop-back does not route transmit data");

  a_loop_mark: assert property (@(posedge hclk) disable iff (!hresetn)
    lb_eff |=> (serial_driver_pair | ~serial_driver_en) == 8'hff)
    else $error("Enabled driver not at logic one in loop-back");

  a_loop_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
    (lb_eff && $past(lb_eff) && $stable(tx_serial_data)) |=>
      $stable(cdr_serial_in))
    else $error("External input leaks through during loop-back");

  a_latch_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    (open_s && !drst_s) |=> serial_driver_en == $past(en_map) &&
      $past(bus_eff) == $past(bus_s))
    else $error("Open latch does not pass enable bus");

  a_drv_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (serial_driver_pair & ~serial_driver_en) == 8'h00)
    else $error("Disabled driver carries data");

  a_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (!open_s && !drst_s && $past(!open_s) && !$past(drst_s)) |->
      $stable(held_reg) ##1 serial_driver_en == $past(en_map))
    else $error("Closed latch lost its value");

  a_reset_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    drst_s |=> held_reg == 8'h00 && serial_driver_en == 8'h00)
    else $error("Device reset did not clear driver enables");

  a_level_pick: assert property (@(posedge hclk) disable iff (!hresetn)
    lvl_s == LVL_MID |=> sig_detect_threshold == TH_MID)
    else $error("Signal detect threshold not selected");

endmodule

`default_nettype wire

// >>> core/serial_port_pkg.sv
/*
 * Constants for the serial port select and enable block: register map,
 * field positions, reset values and signal detect thresholds.
 * Assumes a 32-bit AHB-Lite register bus, word aligned.
 */
package serial_port_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  CTRL_OFF     = 8'h00; // Control, read/write
  localparam logic [7:0]  STATUS_OFF   = 8'h04; // Status, read only
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_LOOP_BIT   = 0;  // Software loop-back force
  localparam int ST_EN_LSB       = 0;  // Driver enables, 8 bits
  localparam int ST_SEL_LSB      = 8;  // Input selectors, 4 bits
  localparam int ST_LOOP_BIT     = 12; // Effective loop-back
  localparam int ST_OPEN_BIT     = 13; // Latch open
  localparam int ST_DRST_BIT     = 14; // Device reset seen
  localparam int ST_LVL_LSB      = 16; // Level select code, 2 bits

  // ****************************************************************
  // Geometry and signal detect
  // ****************************************************************
  localparam int CHANNELS        = 4;
  localparam int DRIVERS         = 8;
  localparam int SYNC_W          = 25;
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [7:0] TH_LOW  = 8'h10; // Plain threshold codes
  localparam logic [7:0] TH_MID  = 8'h20;
  localparam logic [7:0] TH_HIGH = 8'h40;
  localparam logic [23:0] DRV_MAP_DEFAULT = 24'hfac688; // Identity map

endpackage

// >>> core/pin_sync3.sv
/*
 * Three-stage synchroniser for a vector of asynchronous pins.
 * Assumes one clock; an output bit changes once stages two and three agree.
 */
`timescale 1ns/1ns
`default_nettype none

module pin_sync3 #(
  parameter int W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // Three flops, stage one read only by stage two
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a bit only where stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= '0;
    end else begin
      pin_out <= (s2_reg & s3_reg) | (pin_out & (s2_reg | s3_reg));
    end
  end

endmodule

`default_nettype wire

// >>> testbench/fiber_link_model.sv
/*
 * Model of the optical module on the serial lines.
 * Assumes the bench sets the receive pattern and holds it between checks.
 */
`timescale 1ns/1ns
`default_nettype none

module fiber_link_model (
  input  wire logic [3:0] pat,
  input  wire logic [7:0] drv_data,
  input  wire logic [7:0] drv_en,
  output logic      [3:0] primary,
  output logic      [3:0] secondary,
  output logic      [7:0] line
);
  // Primary carries the pattern, secondary its inverse
  assign primary   = pat;
  assign secondary = ~pat;
  // A powered-down driver floats; show the inverse of its data
  assign line = (drv_data & drv_en) | (~drv_data & ~drv_en);
endmodule

`default_nettype wire

// >>> testbench/tb_top.sv
/*
 * Self-checking bench for the serial port select and enable block.
 * Assumes the design of core/ and the link model beside it.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import serial_port_pkg::*;
();
  // ************************************************************
  // Signals
  // ************************************************************
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic        device_reset_n = 1'b1, global_loopback_en = 1'b0;
  logic        drv_enable_latch_open = 1'b0;
  logic [1:0]  htrans = 2'h0, sig_detect_level_sel = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [7:0]  shared_enable_bus = 8'h00;
  logic [3:0]  rx_input_choose = 4'h0, tx_serial_data = 4'h0, pat = 4'h0;
  logic [3:0]  sel, exp4;
  wire  logic  hready, hreadyout, hresp;
  wire  logic [31:0] hrdata;
  wire  logic [3:0]  primary_serial_in, secondary_serial_in, cdr_serial_in;
  wire  logic [7:0]  serial_driver_pair, serial_driver_en;
  wire  logic [7:0]  sig_detect_threshold, line_out;
  int          n_mismatch = 0, comparisons = 0;

  assign hready = hreadyout;
  // Clock of 50 ns
  always #25 hclk = ~hclk;

  serial_port_select_enable dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .device_reset_n, .global_loopback_en, .drv_enable_latch_open,
    .shared_enable_bus, .rx_input_choose, .sig_detect_level_sel,
    .primary_serial_in, .secondary_serial_in, .tx_serial_data,
    .cdr_serial_in, .serial_driver_pair, .serial_driver_en,
    .sig_detect_threshold);

  fiber_link_model link (.pat, .drv_data(serial_driver_pair),
    .drv_en(serial_driver_en), .primary(primary_serial_in),
    .secondary(secondary_serial_in), .line(line_out));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready high at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        stop_test();
      end
      @(posedge hclk);
    end
  endtask

  // One AHB-Lite single transfer; read data left in rd
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    cmp(32'(hresp), 32'h0);
  endtask

  // Pin synchroniser latency plus output register
  task automatic settle;
    repeat (8) @(posedge hclk);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    cmp(32'(serial_driver_en), 32'h0);
    xfer(32'(CTRL_OFF), 1'b0, 32'h0);
    cmp(rd, CTRL_RESET);
    xfer(32'h10, 1'b1, 32'hffff_ffff);
    xfer(32'h10, 1'b0, 32'h0);
    cmp(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      sig_detect_level_sel <= 2'(i);
      settle();
      cmp(32'(sig_detect_threshold), i == 0 ? 32'(TH_LOW) :
          i == 1 ? 32'(TH_MID) : 32'(TH_HIGH));
    end
    pat <= 4'h6;
    for (int i = 0; i < 2; i++) begin
      sel = i == 0 ? 4'ha : 4'h5;
      rx_input_choose <= sel;
      settle();
      // Expected source kept at channel width before widening
      exp4 = (sel & pat) | (~sel & ~pat);
      cmp(32'(cdr_serial_in), 32'(exp4));
    end
    drv_enable_latch_open <= 1'b1;
    shared_enable_bus     <= 8'ha5;
    tx_serial_data        <= 4'h9;
    settle();
    cmp(32'(serial_driver_en), 32'ha5);
    cmp(32'(serial_driver_pair), 32'h81);
    shared_enable_bus <= 8'h5a;
    settle();
    cmp(32'(serial_driver_en), 32'h5a);
    drv_enable_latch_open <= 1'b0;
    settle();
    shared_enable_bus <= 8'hff;
    settle();
    cmp(32'(serial_driver_en), 32'h5a);
    xfer(32'(STATUS_OFF), 1'b0, 32'h0);
    cmp(rd & 32'h20ff, 32'h5a);
    global_loopback_en <= 1'b1;
    tx_serial_data     <= 4'h6;
    pat                <= 4'hf;
    settle();
    cmp(32'(cdr_serial_in), 32'h6);
    cmp(32'(serial_driver_pair), 32'h5a);
    cmp(32'(line_out), 32'hff);
    pat <= 4'h0;
    settle();
    cmp(32'(cdr_serial_in), 32'h6);
    global_loopback_en <= 1'b0;
    settle();
    cmp(32'(cdr_serial_in), 32'ha);
    xfer(32'(CTRL_OFF), 1'b1, 32'h1);
    xfer(32'(CTRL_OFF), 1'b0, 32'h0);
    cmp(rd, 32'h1);
    settle();
    cmp(32'(cdr_serial_in), 32'h6);
    xfer(32'(STATUS_OFF), 1'b0, 32'h0);
    cmp(rd & 32'h1000, 32'h1000);
    xfer(32'(CTRL_OFF), 1'b1, 32'h0);
    // Reset pin held low long enough to be sampled
    device_reset_n <= 1'b0;
    repeat (6) @(posedge hclk);
    cmp(32'(serial_driver_en), 32'h0);
    device_reset_n <= 1'b1;
    settle();
    cmp(32'(serial_driver_en), 32'h0);
    stop_test();
  end
endmodule

`default_nettype wire
